// ---- testbench/bus_trace_qualifier_monitor.sv ----
`timescale 1ns/100ps
module bus_trace_qualifier_monitor
  import trace_qual_pkg::*;
#(
  parameter bit DEEP_MEMORY = 1'b0,
  parameter logic [16:0] DEEP_DEPTH = DEEP_DEPTH_DEFAULT
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // observed bus and outputs
  input wire logic sample_valid,
  input wire bus_sample_type sample,
  input wire logic break_req,
  input wire logic trace_we,
  input wire logic [15:0] trace_waddr,
  input wire trace_entry_type trace_wdata
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic ctrl_wr;
  logic rd_ap;
  logic [16:0] lim;
  // control write, flagged during its data phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ctrl_wr <= 1'b0;
    else
      ctrl_wr <= hsel && htrans[1] && hready && hwrite && haddr == 32'h0;
  assign rd_ap = hsel && htrans[1] && hready && !hwrite;
  assign lim = DEEP_MEMORY ? DEEP_DEPTH : DEPTH_SMALL_FULL;
  sequence run_halt;
    ctrl_wr && hwdata[CTRL_STOP] && !hwdata[CTRL_START];
  endsequence
  sequence quiet;
    !trace_we [*4];
  endsequence
  chk_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus response not okay");
  chk_rdata_stands: assert property (!rd_ap |=> $stable(hrdata))
    else $error("read data moved without a read");
  chk_store_source: assert property (trace_we |-> $past(sample_valid))
    else $error("store without a valid sample");
  chk_entry_sample: assert property
    (trace_we |-> trace_wdata.sample == $past(sample))
    else $error("stored sample differs from bus");
  chk_stop_quiet: assert property (run_halt |=> quiet)
    else $error("store after run stopped");
  chk_break_hold: assert property
    (break_req && !(ctrl_wr && hwdata[1:0] != 2'h0) |=> break_req)
    else $error("break request dropped early");
  chk_break_trig: assert property
    ($rose(break_req) |-> trace_we && trace_wdata.is_trigger)
    else $error("break without trigger entry");
  chk_depth_bound: assert property
    (trace_we |-> {1'b0, trace_waddr} < lim)
    else $error("trace address beyond depth");
  chk_trig_single: assert property
    (trace_we && trace_wdata.is_trigger |=>
     !(trace_we && trace_wdata.is_trigger))
    else $error("trigger entry repeated");
endmodule
bind bus_trace_qualifier bus_trace_qualifier_monitor #(
  .DEEP_MEMORY(DEEP_MEMORY),
  .DEEP_DEPTH(DEEP_DEPTH)
) mon_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hreadyout, .hrdata, .hresp, .sample_valid, .sample,
  .break_req, .trace_we, .trace_waddr, .trace_wdata);

// ---- testbench/bus_trace_qualifier_tb.sv ----
`timescale 1ns/100ps
module bus_trace_qualifier_tb
  import trace_qual_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic sample_valid, break_req, trace_we, irq, drive_en, halted;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [15:0] trace_waddr;
  bus_sample_type sample, drive_val;
  trace_entry_type trace_wdata;
  trace_entry_type q[$];
  logic [15:0] aq[$];
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  bus_trace_qualifier dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
    .hresp, .sample_valid, .sample, .break_req, .trace_we, .trace_waddr,
    .trace_wdata, .irq);
  proc_bus_model bus_u (.hclk, .hresetn, .drive_en, .drive_val,
    .break_req, .sample_valid, .sample, .halted);
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task end_of_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one single transfer, master side
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk32($sformatf("reg %h", a), e, r);
  endtask
  task put(input logic [31:0] a, input logic [15:0] d);
    drive_en <= 1'b1;
    drive_val <= '{addr: a, data: d, status: 16'h0};
    @(posedge hclk);
  endtask
  task gap(input int n);
    drive_en <= 1'b0;
    repeat (n) @(posedge hclk);
  endtask
  // restart waits out the partner's halted state
  task run(input logic [31:0] c);
    q.delete();
    aq.delete();
    wr(OFS_CTRL, c);
    gap(2);
  endtask
  task ent(input int i, input logic [31:0] a, input logic t, input logic p);
    chk32("entry addr", a, q[i].sample.addr);
    chk32("entry trig", {31'h0, t}, {31'h0, q[i].is_trigger});
    chk32("entry pre", {31'h0, p}, {31'h0, q[i].is_prestore});
  endtask
  // capture of the trace write port
  always @(posedge hclk)
    if (trace_we === 1'b1)
    begin
      q.push_back(trace_wdata);
      aq.push_back(trace_waddr);
    end
  // hang guard, tests need about 470 cycles
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      errors++;
      end_of_test();
    end
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    hsize = 3'h2;
    drive_en = 1'b0;
    drive_val = '0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(OFS_CTRL, CTRL_RESET);
    rd(OFS_OCCUR, OCCUR_RESET);
    rd(OFS_QSEL, QSEL_RESET);
    rd(OFS_STATUS, 32'h0);
    rd(8'h2C, 32'h0);
    // range on the trigger only, second hit fires, trigger at bottom
    wr(OFS_QSEL, 32'h0101_0100);
    wr(OFS_RANGE_CTRL, 32'h1);
    wr(OFS_RANGE_LO, 32'h100);
    wr(OFS_RANGE_HI, 32'h1FF);
    wr(OFS_OCCUR, 32'h2);
    run(32'h115);
    put(32'h0FF, 0);
    put(32'h200, 0);
    put(32'h100, 0);
    put(32'h050, 0);
    put(32'h1FF, 0);
    gap(6);
    chk32("stored", 5, q.size());
    ent(2, 32'h100, 0, 0);
    ent(4, 32'h1FF, 1, 0);
    chk32("first addr", 0, aq[0]);
    chk32("break", 1, {31'h0, break_req});
    chk32("halted", 1, {31'h0, halted});
    rd(OFS_STATUS, 32'h3B);
    rd(OFS_INT_STATUS, 32'h3);
    chk32("irq", 0, {31'h0, irq});
    wr(OFS_INT_MASK, 32'h1);
    // the mask lands at the edge ending the write; look one edge later
    @(posedge hclk);
    chk32("irq", 1, {31'h0, irq});
    wr(OFS_INT_STATUS, 32'h3);
    @(posedge hclk);
    chk32("irq", 0, {31'h0, irq});
    // inverted range, first outside cycle fires
    wr(OFS_RANGE_CTRL, 32'h3);
    wr(OFS_OCCUR, 32'h1);
    run(32'h111);
    put(32'h100, 0);
    put(32'h1FF, 0);
    put(32'h200, 0);
    gap(6);
    chk32("stored", 3, q.size());
    ent(2, 32'h200, 1, 0);
    chk32("break", 0, {31'h0, break_req});
    // terms: store 0x300 with data 0x55, trigger 0x400, prestore 0x500
    wr(OFS_RANGE_CTRL, 32'h0);
    wr(OFS_QSEL, 32'h0008_0204);
    wr(8'h50, 32'h300);
    wr(8'h54, 32'hFFFF_FFFF);
    wr(8'h58, 32'hFFFF_0055);
    wr(8'h60, 32'h400);
    wr(8'h64, 32'hFFFF_FFFF);
    wr(8'h70, 32'h500);
    wr(8'h74, 32'hFFFF_FFFF);
    run(32'h181);
    put(32'h300, 16'h55);
    put(32'h300, 16'h56);
    put(32'h301, 16'h55);
    put(32'h500, 0);
    put(32'h400, 0);
    put(32'h300, 16'h55);
    gap(4);
    wr(OFS_CTRL, 32'h182);
    chk32("stored", 3, q.size());
    ent(1, 32'h400, 1, 0);
    ent(2, 32'h300, 0, 0);
    // prestore on, counting stored states, twice to see the clear
    for (int k = 0; k < 2; k++)
    begin
      run(32'h0C1);
      put(32'h500, 0);
      put(32'h301, 0);
      put(32'h300, 16'h55);
      gap(4);
      wr(OFS_CTRL, 32'h0C2);
      chk32("stored", 2, q.size());
      ent(0, 32'h500, 0, 1);
      chk32("entry count", 1, q[1].count);
      chk32("second addr", 1, aq[1]);
      rd(OFS_COUNT, 32'h2);
      rd(OFS_STORED, 32'h2);
    end
    // data range ORed with a term on the trigger, centre, time count
    wr(OFS_RANGE_CTRL, 32'h5);
    wr(OFS_RANGE_LO, 32'h10);
    wr(OFS_RANGE_HI, 32'h20);
    wr(OFS_QSEL, 32'h4);
    wr(OFS_OCCUR, 32'h2);
    run(32'h169);
    put(32'h400, 16'h0);
    put(32'h123, 16'h20);
    for (int i = 0; i < 300; i++)
      put(32'h600 + i, 16'h0);
    gap(4);
    chk32("stored", 32'h102, q.size());
    ent(1, 32'h123, 1, 0);
    chk32("time step", 1, q[3].count - q[2].count);
    chk32("last addr", 32'h101, aq[257]);
    rd(OFS_STORED, 32'h102);
    end_of_test();
  end
endmodule

// ---- testbench/proc_bus_model.sv ----
`timescale 1ns/100ps
module proc_bus_model
  import trace_qual_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bench request
  input wire logic drive_en,
  input wire bus_sample_type drive_val,
  // break control
  input wire logic break_req,
  // observed bus
  output logic sample_valid,
  output bus_sample_type sample,
  output logic halted
);
  logic [1:0] brk_wait;
  // the core reaches its monitor a few cycles after the request
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      brk_wait <= 2'h0;
    else if (!break_req)
      brk_wait <= 2'h0;
    else if (brk_wait != 2'h3)
      brk_wait <= brk_wait + 2'h1;
  assign halted = brk_wait == 2'h3;
  // idle cycles flip the lines so stale values never look valid
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      sample_valid <= 1'b0;
      sample <= '0;
    end
    else
    begin
      sample_valid <= drive_en && !halted;
      sample <= drive_en ? drive_val : ~sample;
    end
endmodule

// ---- verilog/bus_trace_qualifier.sv ----
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module bus_trace_qualifier
  import trace_qual_pkg::*;
#(
  parameter bit DEEP_MEMORY = 1'b0,
  parameter logic [16:0] DEEP_DEPTH = DEEP_DEPTH_DEFAULT
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // observed processor bus
  input wire logic sample_valid,
  input wire bus_sample_type sample,
  // emulator break control
  output logic break_req,
  // trace memory write port
  output logic trace_we,
  output logic [15:0] trace_waddr,
  output trace_entry_type trace_wdata,
  // interrupt
  output logic irq
);

  // one word of each state term: addr value, addr mask, data, status
  logic [31:0] term_word [0:NUM_TERMS-1][0:3];
  logic [31:0] ctrl;
  logic [15:0] occur;
  logic [31:0] qsel;
  logic [31:0] range_ctrl;
  logic [31:0] range_lo;
  logic [31:0] range_hi;
  logic [1:0] int_status;
  logic [1:0] int_mask;
  run_state_type state;
  logic [15:0] occ_cnt;
  logic [31:0] counter;
  logic [16:0] stored;
  logic [16:0] post_left;
  logic triggered;

  logic wr_pend;
  logic [7:0] wr_addr;
  logic start_cmd;
  logic stop_cmd;
  logic range_hit;
  logic [NUM_TERMS-1:0] term_hit;
  logic [3:0] qual_match;
  logic trig_event;
  logic store_now;
  logic pre_hit;
  logic [16:0] depth;
  logic [16:0] next_post;

  // a term matches only if every cared bit of all three fields agrees
  function automatic logic term_match(input logic [31:0] w0,
    input logic [31:0] w1, input logic [31:0] w2, input logic [31:0] w3,
    input bus_sample_type s);
    logic a_ok;
    logic d_ok;
    logic s_ok;
    a_ok = ((s.addr ^ w0) & w1) == 32'h0000_0000;
    d_ok = ((s.data ^ w2[15:0]) & w2[31:16]) == 16'h0000;
    s_ok = ((s.status ^ w3[15:0]) & w3[31:16]) == 16'h0000;
    return a_ok && d_ok && s_ok;
  endfunction

  // field that the range comparator looks at
  function automatic logic [31:0] range_field(input logic [1:0] sel,
    input bus_sample_type s);
    case (sel)
      2'b01: return {16'h0000, s.data};
      2'b10: return {16'h0000, s.status};
      default: return s.addr;
    endcase
  endfunction

  // ---------------- ahb-lite slave ----------------
  // zero wait states; this master never overlaps a write data phase
  // with the next address phase, so the early read sampling is safe
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase capture for writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // read data registered during the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      hrdata <= 32'h0000_0000;
      if (haddr[7:0] >= OFS_TERM_BASE && haddr[31:8] == 24'h000000)
        hrdata <= term_word[haddr[5:4]][haddr[3:2]];
      else if (haddr[31:8] == 24'h000000)
        case (haddr[7:0])
          OFS_CTRL: hrdata <= ctrl;
          OFS_STATUS: hrdata <= {26'h0, triggered, break_req,
                                 state == ST_DONE, state == ST_ARMED ||
                                 state == ST_POST, state};
          OFS_OCCUR: hrdata <= {16'h0000, occur};
          OFS_COUNT: hrdata <= counter;
          OFS_STORED: hrdata <= {15'h0000, stored};
          OFS_INT_STATUS: hrdata <= {30'h0, int_status};
          OFS_INT_MASK: hrdata <= {30'h0, int_mask};
          OFS_RANGE_CTRL: hrdata <= range_ctrl;
          OFS_RANGE_LO: hrdata <= range_lo;
          OFS_RANGE_HI: hrdata <= range_hi;
          OFS_QSEL: hrdata <= qsel;
          default: hrdata <= 32'h0000_0000;
        endcase
    end
  end

  assign start_cmd = wr_pend && wr_addr == OFS_CTRL && hwdata[CTRL_START];
  assign stop_cmd = wr_pend && wr_addr == OFS_CTRL && hwdata[CTRL_STOP];

  // configuration registers; start and stop bits are not kept
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= CTRL_RESET;
      occur <= OCCUR_RESET[15:0];
      qsel <= QSEL_RESET;
      range_ctrl <= 32'h0000_0000;
      range_lo <= 32'h0000_0000;
      range_hi <= 32'h0000_0000;
      int_mask <= 2'b00;
    end
    else if (wr_pend)
      case (wr_addr)
        OFS_CTRL: ctrl <= {23'h0, hwdata[8:2], 2'b00};
        OFS_OCCUR: occur <= hwdata[15:0];
        OFS_QSEL: qsel <= hwdata;
        OFS_RANGE_CTRL: range_ctrl <= {26'h0, hwdata[5:0]};
        OFS_RANGE_LO: range_lo <= hwdata;
        OFS_RANGE_HI: range_hi <= hwdata;
        OFS_INT_MASK: int_mask <= hwdata[1:0];
        default: ;
      endcase
  end

  // state term registers; reset masks clear so each term matches all
  genvar gt;
  genvar gw;
  generate
    for (gt = 0; gt < NUM_TERMS; gt++)
    begin : g_term
      for (gw = 0; gw < 4; gw++)
      begin : g_word
        always_ff @(posedge hclk or negedge hresetn)
        begin
          if (!hresetn)
            term_word[gt][gw] <= 32'h0000_0000;
          else if (wr_pend && wr_addr == OFS_TERM_BASE +
                   8'(gt * 16 + gw * 4))
            term_word[gt][gw] <= hwdata;
        end
      end
      assign term_hit[gt] = term_match(term_word[gt][0],
        term_word[gt][1], term_word[gt][2], term_word[gt][3], sample);
    end
  endgenerate

  // ---------------- qualification ----------------
  // single comparator, inclusive bounds, optional inverted sense
  always_comb
  begin
    logic [31:0] v;
    v = range_field(range_ctrl[RNG_FIELD_LSB +: 2], sample);
    range_hit = (v >= range_lo) && (v <= range_hi);
    range_hit = range_hit ^ range_ctrl[RNG_INV];
  end

  // each qualifier ORs its selected terms; only the owner sees the range
  generate
    for (gt = 0; gt < 4; gt++)
    begin : g_qual
      assign qual_match[gt] = sample_valid &&
        (|(qsel[gt*8 +: NUM_TERMS] & term_hit) ||
         (range_ctrl[RNG_EN] && range_ctrl[RNG_OWNER_LSB +: 2] == 2'(gt)
          && range_hit));
    end
  endgenerate

  // occurrence count of zero is read as one
  assign trig_event = state == ST_ARMED && qual_match[Q_TRIG] &&
    (occ_cnt + 16'h0001 >= occur);

  assign pre_hit = !ctrl[CTRL_PRE_ANY] && qual_match[Q_PRE];
  assign store_now = (state == ST_ARMED || state == ST_POST) &&
    sample_valid && (!ctrl[CTRL_STORE_EN] || qual_match[Q_STORE] ||
    trig_event || pre_hit);

  // depth shrinks only on the small memory when the counter is in use
  always_comb
  begin
    if (DEEP_MEMORY)
      depth = DEEP_DEPTH;
    else if (ctrl[CTRL_CMODE_LSB +: 2] != CM_OFF)
      depth = DEPTH_SMALL_COUNT;
    else
      depth = DEPTH_SMALL_FULL;
  end

  // states kept after the trigger set where the trigger lands
  always_comb
  begin
    case (ctrl[CTRL_POS_LSB +: 2])
      POS_AFTER: next_post = depth - 17'h00001;
      POS_ABOUT: next_post = {1'b0, depth[16:1]};
      default: next_post = 17'h00000;
    endcase
  end

  // ---------------- run sequencing ----------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= ST_IDLE;
      post_left <= 17'h00000;
      triggered <= 1'b0;
    end
    else if (start_cmd)
    begin
      state <= ST_ARMED;
      triggered <= 1'b0;
    end
    else if (stop_cmd)
      state <= ST_DONE;
    else
      case (state)
        ST_ARMED:
          if (trig_event)
          begin
            triggered <= 1'b1;
            post_left <= next_post;
            state <= next_post == 17'h00000 ? ST_DONE : ST_POST;
          end
        ST_POST:
          if (store_now)
          begin
            post_left <= post_left - 17'h00001;
            if (post_left == 17'h00001)
              state <= ST_DONE;
          end
        ST_IDLE: ;
        ST_DONE: ;
        default: state <= ST_IDLE;
      endcase
  end

  // occurrence counter, cleared when a run starts
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      occ_cnt <= 16'h0000;
    else if (start_cmd)
      occ_cnt <= 16'h0000;
    else if (state == ST_ARMED && qual_match[Q_TRIG])
      occ_cnt <= occ_cnt + 16'h0001;
  end

  // state or time counter, cleared when a run starts
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      counter <= 32'h0000_0000;
    else if (start_cmd)
      counter <= 32'h0000_0000;
    else if (state == ST_ARMED || state == ST_POST)
      case (ctrl[CTRL_CMODE_LSB +: 2])
        CM_STATE: counter <= counter + 32'(qual_match[Q_COUNT]);
        CM_ANY: counter <= counter + 32'(store_now);
        CM_TIME: counter <= counter + 32'h0000_0001;
        default: ;
      endcase
  end

  // break request held until the next start or stop
  // the emulator may need several cycles to act on it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      break_req <= 1'b0;
    else if (start_cmd || stop_cmd)
      break_req <= 1'b0;
    else if (trig_event && ctrl[CTRL_BREAK_EN])
      break_req <= 1'b1;
  end

  // trace memory write stream; circular so pre-trigger history wraps
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trace_we <= 1'b0;
      trace_waddr <= 16'h0000;
      trace_wdata <= '0;
      stored <= 17'h00000;
    end
    else
    begin
      trace_we <= store_now && !start_cmd && !stop_cmd;
      if (start_cmd)
      begin
        trace_waddr <= 16'hFFFF;
        stored <= 17'h00000;
      end
      else if (store_now && !stop_cmd)
      begin
        trace_waddr <= (17'(trace_waddr) + 17'h00001 >= depth) ?
          16'h0000 : trace_waddr + 16'h0001;
        if (stored < depth)
          stored <= stored + 17'h00001;
        trace_wdata.sample <= sample;
        trace_wdata.count <= counter;
        trace_wdata.is_trigger <= trig_event;
        trace_wdata.is_prestore <= pre_hit && !qual_match[Q_STORE];
      end
    end
  end

  // sticky interrupt status; a new event beats a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      int_status <= 2'b00;
    else
    begin
      logic [1:0] set_bits;
      logic [1:0] clr_bits;
      set_bits = {state != ST_DONE && !start_cmd &&
                  (stop_cmd || (trig_event && next_post == 17'h00000) ||
                   (state == ST_POST && store_now &&
                    post_left == 17'h00001)),
                  trig_event};
      clr_bits = (wr_pend && wr_addr == OFS_INT_STATUS) ?
        hwdata[1:0] : 2'b00;
      int_status <= (int_status & ~clr_bits) | set_bits;
    end
  end

  assign irq = |(int_status & int_mask);

endmodule

// ---- verilog/trace_qual_pkg.sv ----
package trace_qual_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_OCCUR = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;
  localparam logic [7:0] OFS_STORED = 8'h10;
  localparam logic [7:0] OFS_INT_STATUS = 8'h14;
  localparam logic [7:0] OFS_INT_MASK = 8'h18;
  localparam logic [7:0] OFS_RANGE_CTRL = 8'h1C;
  localparam logic [7:0] OFS_RANGE_LO = 8'h20;
  localparam logic [7:0] OFS_RANGE_HI = 8'h24;
  localparam logic [7:0] OFS_QSEL = 8'h28;
  localparam logic [7:0] OFS_TERM_BASE = 8'h40;

  // control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_BREAK_EN = 2;
  localparam int CTRL_POS_LSB = 3;
  localparam int CTRL_CMODE_LSB = 5;
  localparam int CTRL_STORE_EN = 7;
  localparam int CTRL_PRE_ANY = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0100;

  // range control fields
  localparam int RNG_EN = 0;
  localparam int RNG_INV = 1;
  localparam int RNG_FIELD_LSB = 2;
  localparam int RNG_OWNER_LSB = 4;

  // interrupt bits
  localparam int IRQ_TRIG = 0;
  localparam int IRQ_DONE = 1;

  // qualifier indices, one select byte each
  localparam int Q_TRIG = 0;
  localparam int Q_STORE = 1;
  localparam int Q_PRE = 2;
  localparam int Q_COUNT = 3;
  localparam int NUM_TERMS = 4;
  localparam logic [31:0] QSEL_RESET = 32'h0101_0101;
  localparam logic [31:0] OCCUR_RESET = 32'h0000_0001;

  // trace depths
  localparam logic [16:0] DEPTH_SMALL_COUNT = 17'h00200;
  localparam logic [16:0] DEPTH_SMALL_FULL = 17'h00400;
  localparam logic [16:0] DEEP_DEPTH_DEFAULT = 17'h08000;

  typedef enum logic [1:0] {
    CM_OFF = 2'b00,
    CM_STATE = 2'b01,
    CM_ANY = 2'b10,
    CM_TIME = 2'b11
  } count_mode_type;

  typedef enum logic [1:0] {
    POS_AFTER = 2'b00,
    POS_ABOUT = 2'b01,
    POS_BEFORE = 2'b10
  } trig_pos_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_POST = 2'b10,
    ST_DONE = 2'b11
  } run_state_type;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] data;
    logic [15:0] status;
  } bus_sample_type;

  typedef struct packed {
    bus_sample_type sample;
    logic [31:0] count;
    logic is_trigger;
    logic is_prestore;
  } trace_entry_type;

endpackage
